// ===== pam_map.vh
// Purpose: constants for the port address and payload mapper
// Assumes: 16-bit link words, control words marked by the link control line
// Notes: definitions only
`ifndef PAM_MAP_VH
`define PAM_MAP_VH

// control word field positions
`define PAM_TYPE_HI_BIT     15
`define PAM_TYPE_LO_BIT     12
`define PAM_EOP_HI_BIT      14
`define PAM_EOP_LO_BIT      13
`define PAM_ADR_HI_BIT      11
`define PAM_ADR_LO_BIT      4

// control word type codes {bit15, bit12}
`define PAM_TYPE_IDLE       2'h0
`define PAM_TYPE_ADDR       2'h1
`define PAM_TYPE_PAY_CONT   2'h2
`define PAM_TYPE_PAY_SOP    2'h3

// end of packet status codes
`define PAM_EOP_NONE        2'h0
`define PAM_EOP_ABORT       2'h1
`define PAM_EOP_TWO         2'h2
`define PAM_EOP_ONE         2'h3

// port address sizes
`define PAM_ADDR_BYTES_MAX  18
`define PAM_ADDR_LIMIT      5'h12
`define PAM_ADDR_W          144
`define PAM_ADDR_DATA_MAX   4'h8
`define PAM_POS_MAX         5'h1f

// payload mapping modes
`define PAM_MODE_PACKET     2'h0
`define PAM_MODE_CELL52     2'h1
`define PAM_MODE_CELL54     2'h2

// cell word counts and word positions
`define PAM_CELL52_WORDS    6'h1a
`define PAM_CELL54_WORDS    6'h1b
`define PAM_HEADER_WORDS    6'h02
`define PAM_CHECK_WORD_IDX  6'h02
`define PAM_WORDS_MAX       6'h3f

// word kind codes
`define PAM_KIND_PAYLOAD    2'h0
`define PAM_KIND_HEADER     2'h1
`define PAM_KIND_CHECK      2'h2

`define PAM_PAD_ZERO        8'h00

`endif

// ===== pam_mapper.v
// Purpose: sink side of the link; assembles port addresses and unpacks payload words
// Assumes: partner changes link_ctl/link_data on the falling link clock edge
// Notes: link inputs sampled on clk through three flops; words taken at rising link edge
`timescale 1ns/1ps
`default_nettype none
`include "pam_map.vh"

module pam_mapper
(
	input  wire          clk,                          // system clock, 50 MHz
	input  wire          arst_n,                       // async reset, active low
	input  wire          link_clk,                     // link word clock
	input  wire          link_ctl,                     // high marks a control word
	input  wire [15:0]   link_data,                    // link word
	input  wire [4:0]    physical_address_byte_count,  // physical field width in bytes
	input  wire [4:0]    sink_address_byte_limit,      // bytes this sink keeps
	input  wire [15:0]   top_physical_address,         // highest physical port served
	input  wire [1:0]    cell_mode,                    // packet, 52-byte or 54-byte cell
	output wire [143:0]  port_address,                 // assembled port address
	output wire [4:0]    address_byte_count,           // bytes kept in port_address
	output wire          address_done,                 // pulse, address complete
	output wire          start_of_packet,              // transfer opened a packet
	output wire [15:0]   physical_port,                // decoded physical port
	output wire          port_in_range,                // physical port served here
	output wire          address_mismatch,             // pulse, continuation address differs
	output wire          address_overrun,              // pulse, too many address data words
	output wire [15:0]   payload_word,                 // received data word
	output wire          payload_valid,                // pulse, payload_word new
	output wire [1:0]    word_kind,                    // payload, header or check word
	output wire [7:0]    check_byte,                   // header check byte, 54-byte cells
	output wire [7:0]    user_defined_pad_byte,        // pad byte, 54-byte cells
	output wire          end_of_packet,                // pulse, packet ended
	output wire [1:0]    end_of_packet_status,         // status of last ending
	output wire          transfer_end,                 // pulse, transfer closed
	output wire          pad_error,                    // pulse, odd pad byte not zero
	output wire          cell_length_error             // pulse, cell ended at wrong length
);

	localparam [1:0] ST_IDLE = 2'h0;
	localparam [1:0] ST_ADDR = 2'h1;
	localparam [1:0] ST_DATA = 2'h2;

	// write one byte at its arrival position unless beyond the kept width
	function [`PAM_ADDR_W-1:0] pam_place;
		input [`PAM_ADDR_W-1:0] a;
		input [4:0]             idx;
		input [4:0]             lim;
		input [7:0]             b;
		integer i;
		begin
			pam_place = a;
			for (i = 0; i < `PAM_ADDR_BYTES_MAX; i = i + 1)
				if (i == idx && idx < lim)
					pam_place[i*8 +: 8] = b;
		end
	endfunction

	// physical bytes above the low two must be zero for a served port
	function pam_in_range;
		input [`PAM_ADDR_W-1:0] a;
		input [4:0]             n;
		input [15:0]            low;
		input [15:0]            top;
		integer i;
		reg     hi_zero;
		begin
			hi_zero = 1'b1;
			for (i = 2; i < `PAM_ADDR_BYTES_MAX; i = i + 1)
				if (i < n && a[i*8 +: 8] != `PAM_PAD_ZERO)
					hi_zero = 1'b0;
			pam_in_range = hi_zero && (low <= top);
		end
	endfunction

	// link synchronisers
	reg         lclk_s1_ff, lclk_s2_ff, lclk_s3_ff;
	reg         ctl_s1_ff, ctl_s2_ff, ctl_s3_ff;
	reg  [15:0] dat_s1_ff, dat_s2_ff, dat_s3_ff;
	reg         lclk_level_ff;

	// block state
	reg  [1:0]            state_ff, nxt_state;
	reg  [`PAM_ADDR_W-1:0] addr_ff, nxt_addr;
	reg  [4:0]            pos_ff, nxt_pos;
	reg  [3:0]            adw_cnt_ff, nxt_adw_cnt;
	reg  [`PAM_ADDR_W-1:0] pkt_addr_ff, nxt_pkt_addr;
	reg                   pkt_open_ff, nxt_pkt_open;
	reg  [5:0]            pkt_words_ff, nxt_pkt_words;
	reg  [7:0]            last_lo_ff, nxt_last_lo;

	// output registers
	reg  [`PAM_ADDR_W-1:0] port_address_ff, nxt_port_address;
	reg  [4:0]            addr_count_ff, nxt_addr_count;
	reg                   addr_done_ff, nxt_addr_done;
	reg                   sop_ff, nxt_sop;
	reg  [15:0]           phys_port_ff, nxt_phys_port;
	reg                   in_range_ff, nxt_in_range;
	reg                   mismatch_ff, nxt_mismatch;
	reg                   overrun_ff, nxt_overrun;
	reg  [15:0]           pay_word_ff, nxt_pay_word;
	reg                   pay_valid_ff, nxt_pay_valid;
	reg  [1:0]            kind_ff, nxt_kind;
	reg  [7:0]            check_ff, nxt_check;
	reg  [7:0]            pad_ff, nxt_pad;
	reg                   eop_ff, nxt_eop;
	reg  [1:0]            eop_status_ff, nxt_eop_status;
	reg                   xfer_end_ff, nxt_xfer_end;
	reg                   pad_err_ff, nxt_pad_err;
	reg                   cell_err_ff, nxt_cell_err;

	wire        word_strobe;
	wire [1:0]  cw_type;
	wire [1:0]  cw_eop;
	wire [7:0]  cw_adr;
	wire [4:0]  kept_limit;
	wire [4:0]  phys_bytes;

	// a rising link edge counts once the second and third samples agree high
	assign word_strobe = lclk_s2_ff && lclk_s3_ff && !lclk_level_ff;
	assign cw_type     = {dat_s3_ff[`PAM_TYPE_HI_BIT], dat_s3_ff[`PAM_TYPE_LO_BIT]};
	assign cw_eop      = dat_s3_ff[`PAM_EOP_HI_BIT:`PAM_EOP_LO_BIT];
	assign cw_adr      = dat_s3_ff[`PAM_ADR_HI_BIT:`PAM_ADR_LO_BIT];
	// never keep more than the largest legal address
	assign kept_limit  = (sink_address_byte_limit > `PAM_ADDR_LIMIT) ?
	                     `PAM_ADDR_LIMIT : sink_address_byte_limit;
	assign phys_bytes  = (physical_address_byte_count > kept_limit) ?
	                     kept_limit : physical_address_byte_count;

	// three-flop synchronisers; first stage feeds only the second
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			lclk_s1_ff    <= 1'b0;
			lclk_s2_ff    <= 1'b0;
			lclk_s3_ff    <= 1'b0;
			ctl_s1_ff     <= 1'b0;
			ctl_s2_ff     <= 1'b0;
			ctl_s3_ff     <= 1'b0;
			dat_s1_ff     <= 16'h0000;
			dat_s2_ff     <= 16'h0000;
			dat_s3_ff     <= 16'h0000;
			lclk_level_ff <= 1'b0;
		end
		else
		begin
			lclk_s1_ff <= link_clk;
			lclk_s2_ff <= lclk_s1_ff;
			lclk_s3_ff <= lclk_s2_ff;
			ctl_s1_ff  <= link_ctl;
			ctl_s2_ff  <= ctl_s1_ff;
			ctl_s3_ff  <= ctl_s2_ff;
			dat_s1_ff  <= link_data;
			dat_s2_ff  <= dat_s1_ff;
			dat_s3_ff  <= dat_s2_ff;
			// filtered link clock level, moves only on agreement
			if (lclk_s2_ff == lclk_s3_ff)
				lclk_level_ff <= lclk_s3_ff;
		end
	end

	// word decode; data is stable half a link period after the rising edge
	always @*
	begin
		nxt_state        = state_ff;
		nxt_addr         = addr_ff;
		nxt_pos          = pos_ff;
		nxt_adw_cnt      = adw_cnt_ff;
		nxt_pkt_addr     = pkt_addr_ff;
		nxt_pkt_open     = pkt_open_ff;
		nxt_pkt_words    = pkt_words_ff;
		nxt_last_lo      = last_lo_ff;
		nxt_port_address = port_address_ff;
		nxt_addr_count   = addr_count_ff;
		nxt_sop          = sop_ff;
		nxt_phys_port    = phys_port_ff;
		nxt_in_range     = in_range_ff;
		nxt_pay_word     = pay_word_ff;
		nxt_kind         = kind_ff;
		nxt_check        = check_ff;
		nxt_pad          = pad_ff;
		nxt_eop_status   = eop_status_ff;
		nxt_addr_done    = 1'b0;
		nxt_mismatch     = 1'b0;
		nxt_overrun      = 1'b0;
		nxt_pay_valid    = 1'b0;
		nxt_eop          = 1'b0;
		nxt_xfer_end     = 1'b0;
		nxt_pad_err      = 1'b0;
		nxt_cell_err     = 1'b0;
		if (word_strobe && ctl_s3_ff)
		begin
			// first control word after a burst closes the transfer
			if (state_ff == ST_DATA)
			begin
				nxt_xfer_end   = 1'b1;
				nxt_eop_status = cw_eop;
				if (cw_eop != `PAM_EOP_NONE)
				begin
					nxt_eop      = 1'b1;
					nxt_pkt_open = 1'b0;
				end
				// odd ending must have left a zero low half
				if (cw_eop == `PAM_EOP_ONE && last_lo_ff != `PAM_PAD_ZERO)
					nxt_pad_err = 1'b1;
				// cells end on a fixed even length
				if (cell_mode == `PAM_MODE_CELL52 && (cw_eop == `PAM_EOP_ONE ||
				    (cw_eop == `PAM_EOP_TWO && pkt_words_ff != `PAM_CELL52_WORDS)))
					nxt_cell_err = 1'b1;
				if (cell_mode == `PAM_MODE_CELL54 && (cw_eop == `PAM_EOP_ONE ||
				    (cw_eop == `PAM_EOP_TWO && pkt_words_ff != `PAM_CELL54_WORDS)))
					nxt_cell_err = 1'b1;
				nxt_state = ST_IDLE;
			end
			case (cw_type)
				`PAM_TYPE_ADDR:
				begin
					// fresh transfer: clear, then least significant byte first
					nxt_addr    = pam_place({`PAM_ADDR_W{1'b0}}, 5'h00, kept_limit, cw_adr);
					nxt_pos     = 5'h01;
					nxt_adw_cnt = 4'h0;
					nxt_state   = ST_ADDR;
				end
				`PAM_TYPE_PAY_CONT, `PAM_TYPE_PAY_SOP:
				begin
					// payload control carries the most significant byte
					if (state_ff == ST_ADDR)
						nxt_addr = pam_place(addr_ff, pos_ff, kept_limit, cw_adr);
					else
					begin
						nxt_addr = pam_place({`PAM_ADDR_W{1'b0}}, 5'h00, kept_limit, cw_adr);
						nxt_pos  = 5'h00;
					end
					// count what was kept; excess bytes were dropped above
					// compare before adding so a saturated position cannot wrap to zero
					if (nxt_pos >= kept_limit)
						nxt_addr_count = kept_limit;
					else
						nxt_addr_count = nxt_pos + 5'h01;
					nxt_port_address = nxt_addr;
					nxt_addr_done    = 1'b1;
					// decode only the physical field; higher bytes stay extended
					if (phys_bytes == 5'h00)
						nxt_phys_port = 16'h0000;
					else if (phys_bytes == 5'h01)
						nxt_phys_port = {8'h00, nxt_addr[7:0]};
					else
						nxt_phys_port = nxt_addr[15:0];
					nxt_in_range = pam_in_range(nxt_addr, phys_bytes, nxt_phys_port,
					                            top_physical_address);
					nxt_sop = (cw_type == `PAM_TYPE_PAY_SOP);
					if (cw_type == `PAM_TYPE_PAY_SOP)
					begin
						// packet or cell always opens a transfer
						nxt_pkt_addr  = nxt_addr;
						nxt_pkt_open  = 1'b1;
						nxt_pkt_words = 6'h00;
					end
					else if (!pkt_open_ff || nxt_addr != pkt_addr_ff)
						nxt_mismatch = 1'b1;
					nxt_state = ST_DATA;
				end
				default:
				begin
					// idle or training word ends any address in progress
					nxt_state = ST_IDLE;
				end
			endcase
		end
		else if (word_strobe && state_ff == ST_ADDR)
		begin
			// two address bytes per word, lower half less significant
			if (adw_cnt_ff == `PAM_ADDR_DATA_MAX)
				nxt_overrun = 1'b1;
			else
				nxt_adw_cnt = adw_cnt_ff + 4'h1;
			// upper byte index saturates too, else it would overwrite byte zero
			nxt_addr = pam_place(pam_place(addr_ff, pos_ff, kept_limit, dat_s3_ff[7:0]),
			                     (pos_ff == `PAM_POS_MAX) ? `PAM_POS_MAX : pos_ff + 5'h01,
			                     kept_limit, dat_s3_ff[15:8]);
			// saturate so a long run can never wrap into low bytes
			if (pos_ff >= `PAM_POS_MAX - 5'h01)
				nxt_pos = `PAM_POS_MAX;
			else
				nxt_pos = pos_ff + 5'h02;
		end
		else if (word_strobe && state_ff == ST_DATA)
		begin
			// earlier byte in the upper half, delivered unchanged
			nxt_pay_word  = dat_s3_ff;
			nxt_pay_valid = 1'b1;
			nxt_last_lo   = dat_s3_ff[7:0];
			nxt_kind      = `PAM_KIND_PAYLOAD;
			if (cell_mode != `PAM_MODE_PACKET && pkt_words_ff < `PAM_HEADER_WORDS)
				nxt_kind = `PAM_KIND_HEADER;
			if (cell_mode == `PAM_MODE_CELL54 && pkt_words_ff == `PAM_CHECK_WORD_IDX)
			begin
				nxt_kind  = `PAM_KIND_CHECK;
				nxt_check = dat_s3_ff[15:8];
				nxt_pad   = dat_s3_ff[7:0];
			end
			// word count spans segments of one packet
			if (pkt_words_ff != `PAM_WORDS_MAX)
				nxt_pkt_words = pkt_words_ff + 6'h01;
		end
	end

	// state and output registers
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_ff        <= ST_IDLE;
			addr_ff         <= {`PAM_ADDR_W{1'b0}};
			pos_ff          <= 5'h00;
			adw_cnt_ff      <= 4'h0;
			pkt_addr_ff     <= {`PAM_ADDR_W{1'b0}};
			pkt_open_ff     <= 1'b0;
			pkt_words_ff    <= 6'h00;
			last_lo_ff      <= 8'h00;
			port_address_ff <= {`PAM_ADDR_W{1'b0}};
			addr_count_ff   <= 5'h00;
			addr_done_ff    <= 1'b0;
			sop_ff          <= 1'b0;
			phys_port_ff    <= 16'h0000;
			in_range_ff     <= 1'b0;
			mismatch_ff     <= 1'b0;
			overrun_ff      <= 1'b0;
			pay_word_ff     <= 16'h0000;
			pay_valid_ff    <= 1'b0;
			kind_ff         <= `PAM_KIND_PAYLOAD;
			check_ff        <= 8'h00;
			pad_ff          <= 8'h00;
			eop_ff          <= 1'b0;
			eop_status_ff   <= `PAM_EOP_NONE;
			xfer_end_ff     <= 1'b0;
			pad_err_ff      <= 1'b0;
			cell_err_ff     <= 1'b0;
		end
		else
		begin
			state_ff        <= nxt_state;
			addr_ff         <= nxt_addr;
			pos_ff          <= nxt_pos;
			adw_cnt_ff      <= nxt_adw_cnt;
			pkt_addr_ff     <= nxt_pkt_addr;
			pkt_open_ff     <= nxt_pkt_open;
			pkt_words_ff    <= nxt_pkt_words;
			last_lo_ff      <= nxt_last_lo;
			port_address_ff <= nxt_port_address;
			addr_count_ff   <= nxt_addr_count;
			addr_done_ff    <= nxt_addr_done;
			sop_ff          <= nxt_sop;
			phys_port_ff    <= nxt_phys_port;
			in_range_ff     <= nxt_in_range;
			mismatch_ff     <= nxt_mismatch;
			overrun_ff      <= nxt_overrun;
			pay_word_ff     <= nxt_pay_word;
			pay_valid_ff    <= nxt_pay_valid;
			kind_ff         <= nxt_kind;
			check_ff        <= nxt_check;
			pad_ff          <= nxt_pad;
			eop_ff          <= nxt_eop;
			eop_status_ff   <= nxt_eop_status;
			xfer_end_ff     <= nxt_xfer_end;
			pad_err_ff      <= nxt_pad_err;
			cell_err_ff     <= nxt_cell_err;
		end
	end

	// outputs straight from registers
	assign port_address          = port_address_ff;
	assign address_byte_count    = addr_count_ff;
	assign address_done          = addr_done_ff;
	assign start_of_packet       = sop_ff;
	assign physical_port         = phys_port_ff;
	assign port_in_range         = in_range_ff;
	assign address_mismatch      = mismatch_ff;
	assign address_overrun       = overrun_ff;
	assign payload_word          = pay_word_ff;
	assign payload_valid         = pay_valid_ff;
	assign word_kind             = kind_ff;
	assign check_byte            = check_ff;
	assign user_defined_pad_byte = pad_ff;
	assign end_of_packet         = eop_ff;
	assign end_of_packet_status  = eop_status_ff;
	assign transfer_end          = xfer_end_ff;
	assign pad_error             = pad_err_ff;
	assign cell_length_error     = cell_err_ff;

endmodule // pam_mapper

`default_nettype wire

// ===== pam_mapper_properties.sv
// Purpose: output timing checks for the port address mapper
// Assumes: one clock domain, asynchronous active-low reset
// Notes: pulses and the registers they qualify land on one edge
`timescale 1ns/1ps
`default_nettype none
`include "pam_map.vh"
module pam_mapper_chk (
	input wire logic         clk,                     // system clock
	input wire logic         arst_n,                  // reset, active low
	input wire logic [4:0]   sink_address_byte_limit, // kept bytes
	input wire logic [1:0]   cell_mode,               // mapping mode
	input wire logic [143:0] port_address,            // assembled address
	input wire logic [4:0]   address_byte_count,      // kept count
	input wire logic         address_done,            // address pulse
	input wire logic         start_of_packet,         // sop level
	input wire logic         address_mismatch,        // mismatch pulse
	input wire logic         payload_valid,           // data pulse
	input wire logic [1:0]   word_kind,               // word class
	input wire logic         end_of_packet,           // eop pulse
	input wire logic [1:0]   end_of_packet_status,    // last status
	input wire logic         transfer_end,            // end pulse
	input wire logic         pad_error,               // pad pulse
	input wire logic         cell_length_error        // length pulse
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	// address side: words are 8 clk apart, so pulses never merge
	a_done_pulse: assert property (address_done |=> !address_done)
		else $error("address done held too long");
	a_count_cap: assert property (address_done |-> address_byte_count <= sink_address_byte_limit
		&& address_byte_count <= 5'h12) else $error("address count over limit");
	a_high_zero: assert property (address_done |-> (port_address >> {address_byte_count, 3'h0}) == '0)
		else $error("unsent address bytes not zero");
	a_addr_hold: assert property ($changed(port_address) |-> address_done)
		else $error("address moved without completion");
	a_mis_cont: assert property (address_mismatch |-> address_done && !start_of_packet)
		else $error("mismatch outside continuation");
	// payload side
	a_data_pulse: assert property (payload_valid |=> !payload_valid)
		else $error("payload valid held too long");
	a_pkt_kind: assert property (payload_valid && cell_mode == `PAM_MODE_PACKET
		|-> word_kind == `PAM_KIND_PAYLOAD) else $error("packet word not payload");
	a_eop_end: assert property (end_of_packet |-> transfer_end
		&& end_of_packet_status != `PAM_EOP_NONE) else $error("eop without ending");
	a_pad_one: assert property (pad_error |-> end_of_packet
		&& end_of_packet_status == `PAM_EOP_ONE) else $error("pad error without odd end");
	a_len_cell: assert property (cell_length_error |-> end_of_packet
		&& cell_mode != `PAM_MODE_PACKET) else $error("length error outside cell");
	c_done: cover property (address_done && address_byte_count == 5'h12);
	c_pad: cover property (pad_error);
	c_len: cover property (cell_length_error);
endmodule // pam_mapper_chk
bind pam_mapper pam_mapper_chk u_chk (.*);
`default_nettype wire

// ===== pam_src.sv
// Purpose: link source model feeding words to the mapper
// Assumes: word set up while link clock low, taken at its rise
// Notes: clock stands still between words; released lines inverted
`timescale 1ns/1ps
`default_nettype none
module pam_src (
	output logic        link_clk,  // word clock, idle low
	output logic        link_ctl,  // control word flag
	output logic [15:0] link_data  // link word
);
	// idle state before the first word
	initial
	begin
		link_clk = 1'b0;
		link_ctl = 1'b0;
		link_data = 16'h0000;
	end
	// one word per 160 ns; every change lands 7 ns after a clk edge, never on it
	task automatic send(input logic c, input logic [15:0] d);
		#7 link_ctl = c;
		link_data = d;
		#20 link_clk = 1'b1;
		#80 link_clk = 1'b0;
		link_ctl = ~c;
		link_data = ~d; // stale value must not look valid
		#53;
	endtask
endmodule // pam_src
`default_nettype wire

// ===== port_address_payload_mapper_tb.sv
// Purpose: directed transfers through the mapper with checks
// Assumes: outputs settle within 8 clk of the closing word
// Notes: pulses counted by a monitor, compared only after the transfers that test them
`timescale 1ns/1ps
`default_nettype none
`include "pam_map.vh"
module port_address_payload_mapper_tb;
	logic clk, arst_n, link_clk, link_ctl, address_done, start_of_packet, port_in_range;
	logic address_mismatch, address_overrun, payload_valid, end_of_packet, transfer_end;
	logic pad_error, cell_length_error;
	logic [15:0] link_data, top_physical_address, physical_port, payload_word;
	logic [4:0] physical_address_byte_count, sink_address_byte_limit, address_byte_count;
	logic [1:0] cell_mode, word_kind, end_of_packet_status;
	logic [143:0] port_address;
	logic [7:0] check_byte, user_defined_pad_byte;
	logic [15:0] pq[$];
	logic [1:0] kq[$];
	int n_fail, check_count, n_mis, n_ovr, n_pad, n_len, n_eop, n_end;
	pam_mapper DUT (.*);
	pam_src u_src (.link_clk, .link_ctl, .link_data);
	// clock; reset is driven by the test sequence below
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// monitor collects data words and pulse counts mid-cycle, where outputs have settled
	always @(negedge clk)
	begin
		if (payload_valid === 1'b1)
		begin
			pq.push_back(payload_word);
			kq.push_back(word_kind);
		end
		n_mis += (address_mismatch === 1'b1);
		n_ovr += (address_overrun === 1'b1);
		n_pad += (pad_error === 1'b1);
		n_len += (cell_length_error === 1'b1);
		n_eop += (end_of_packet === 1'b1);
		n_end += (transfer_end === 1'b1);
	end
	function automatic logic [7:0] ab(int i);
		return 8'ha0 + i[7:0];
	endfunction
	function automatic logic [15:0] dw(int i, int nw, logic [7:0] lo);
		logic [15:0] w;
		w = 16'h0102 + 16'h0202 * i[15:0];
		return (i == nw - 1) ? {w[15:8], lo} : w;
	endfunction
	function automatic logic [143:0] pa(int n, int lim);
		logic [143:0] r;
		r = '0;
		for (int i = 0; i < n && i < lim; i++) r[8*i+:8] = ab(i);
		return r;
	endfunction
	function automatic logic [15:0] cw(logic [1:0] t, logic [1:0] e, logic [7:0] a);
		return {t[1], e, t[0], a, 4'h0};
	endfunction
	task automatic chk(input logic [143:0] g, input logic [143:0] e);
		check_count++;
		if (g !== e)
		begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic cfg(input logic [4:0] lim, input logic [15:0] top, input logic [1:0] m);
		@(posedge clk);
		#7 sink_address_byte_limit = lim;
		top_physical_address = top;
		cell_mode = m;
	endtask
	// one transfer: address bytes, data words, closing idle word
	task automatic run(int n, logic [1:0] t, int nw, logic [7:0] lo, logic [1:0] e);
		@(posedge clk);
		pq = {};
		kq = {};
		{n_mis, n_ovr, n_pad, n_len, n_eop, n_end} = '0;
		if (n > 1) u_src.send(1'b1, cw(`PAM_TYPE_ADDR, 2'h0, ab(0)));
		for (int i = 1; i < n - 1; i += 2) u_src.send(1'b0, {ab(i + 1), ab(i)});
		u_src.send(1'b1, cw(t, 2'h0, ab(n - 1)));
		for (int i = 0; i < nw; i++) u_src.send(1'b0, dw(i, nw, lo));
		u_src.send(1'b1, cw(`PAM_TYPE_IDLE, e, 8'h00));
		repeat (8) @(posedge clk);
		chk(pq.size(), nw);
		for (int i = 0; i < nw && i < pq.size(); i++) chk(pq[i], dw(i, nw, lo));
	endtask
	// watchdog, run needs about 28 us
	initial
	begin
		#300us;
		n_fail++;
		close_out();
	end
	initial
	begin
		arst_n = 1'b0;
		physical_address_byte_count = 5'h02;
		sink_address_byte_limit = 5'h12;
		top_physical_address = 16'ha1a0;
		cell_mode = `PAM_MODE_PACKET;
		repeat (10) @(posedge clk);
		#7 arst_n = 1'b1;
		repeat (4) @(posedge clk);
		run(6, `PAM_TYPE_PAY_SOP, 5, 8'h00, `PAM_EOP_ONE);
		chk(port_address, pa(6, 18));
		chk(address_byte_count, 6);
		chk(physical_port, 16'ha1a0);
		chk({port_in_range, start_of_packet, n_pad, n_eop}, {2'h3, 32'd0, 32'd1});
		chk(end_of_packet_status, `PAM_EOP_ONE);
		run(4, `PAM_TYPE_PAY_SOP, 2, 8'h11, `PAM_EOP_NONE);
		chk({n_end, n_eop}, {32'd1, 32'd0});
		run(4, `PAM_TYPE_PAY_CONT, 3, 8'h22, `PAM_EOP_TWO);
		chk({n_mis, start_of_packet, end_of_packet_status}, {32'd0, 1'b0, `PAM_EOP_TWO});
		run(2, `PAM_TYPE_PAY_CONT, 1, 8'h33, `PAM_EOP_TWO);
		chk(n_mis, 1);
		run(2, `PAM_TYPE_PAY_SOP, 1, 8'h33, `PAM_EOP_NONE);
		run(4, `PAM_TYPE_PAY_CONT, 1, 8'h33, `PAM_EOP_TWO);
		chk({n_mis, address_byte_count}, {32'd1, 5'h04});
		cfg(5'h03, 16'ha19f, `PAM_MODE_PACKET);
		run(6, `PAM_TYPE_PAY_SOP, 1, 8'h44, `PAM_EOP_TWO);
		chk(port_address, pa(6, 3));
		chk({address_byte_count, port_in_range}, {5'h03, 1'b0});
		run(1, `PAM_TYPE_PAY_SOP, 1, 8'h55, `PAM_EOP_ABORT);
		chk(port_address, pa(1, 3));
		chk({address_byte_count, physical_port}, {5'h01, 16'h00a0});
		chk({port_in_range, end_of_packet_status}, {1'b1, `PAM_EOP_ABORT});
		cfg(5'h12, 16'ha1a0, `PAM_MODE_PACKET);
		run(2, `PAM_TYPE_PAY_SOP, 2, 8'h5a, `PAM_EOP_ONE);
		chk(n_pad, 1);
		run(20, `PAM_TYPE_PAY_SOP, 1, 8'h66, `PAM_EOP_TWO);
		chk({n_ovr, address_byte_count}, {32'd1, 5'h12});
		chk(port_address, pa(20, 18));
		cfg(5'h12, 16'ha1a0, `PAM_MODE_CELL54);
		run(4, `PAM_TYPE_PAY_SOP, 27, 8'h77, `PAM_EOP_TWO);
		chk({n_len, kq[0], kq[1], kq[2], kq[3]}, {32'd0, 8'h58});
		chk({check_byte, user_defined_pad_byte}, dw(2, 27, 8'h77));
		cfg(5'h12, 16'ha1a0, `PAM_MODE_CELL52);
		run(4, `PAM_TYPE_PAY_SOP, 26, 8'h88, `PAM_EOP_TWO);
		chk({n_len, kq[0], kq[1], kq[2]}, {32'd0, 6'h14});
		run(4, `PAM_TYPE_PAY_SOP, 27, 8'h99, `PAM_EOP_TWO);
		chk(n_len, 1);
		close_out();
	end
	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
endmodule // port_address_payload_mapper_tb
`default_nettype wire
